// >>> verilog/art_pkg.sv
// Package of constants, field layouts and the state carrier for the auto-reload timers.
// Assumes a single 100 MHz system clock and a byte-wide special-function-register port.
package art_pkg;

  // ****************************************
  // Register map and field positions
  // ****************************************
  localparam logic [7:0] ART_SECOND_TIMER_CONTROL_ADDR    = 8'h91;
  localparam logic [7:0] ART_SECOND_TIMER_RELOAD_LOW_ADDR = 8'h92;
  localparam int         ART_CTL_FLAG_BIT   = 7;
  localparam int         ART_CTL_RUN_BIT    = 2;
  localparam int         ART_CTL_MODE_BIT   = 1;
  localparam int         ART_CTL_XCLK_BIT   = 0;
  localparam logic [7:0] ART_CTL_USED_MASK  = 8'h87;
  localparam logic [7:0] ART_CTL_RESET      = 8'h00;
  localparam logic [7:0] ART_RELOAD_RESET   = 8'h00;
  localparam logic [15:0] ART_COUNT_RESET   = 16'h0000;
  localparam logic [15:0] ART_COUNT_MAX     = 16'hFFFF;

  // ****************************************
  // Clock dividers
  // ****************************************
  localparam int         ART_SYS_DIV       = 12;
  localparam int         ART_XOSC_DIV      = 8;
  localparam logic [3:0] ART_SYS_DIV_LAST  = 4'(ART_SYS_DIV - 1);
  localparam logic [2:0] ART_XOSC_DIV_LAST = 3'(ART_XOSC_DIV - 1);

  // First-timer settings, driven by the core's own register logic.
  typedef struct packed {
    logic        run;                      // Run bit.
    logic        counter_source_select;    // 1: count pin edges, 0: system clock.
    logic        capture_reload_select;    // 0: auto-reload mode.
    logic        external_trigger_enable;  // Trigger pin may force a reload.
    logic        irq_enable;               // Interrupt enable.
    logic [15:0] reload;                   // High and low reload bytes.
  } art_first_cfg_t;

  // Whole state of the block.
  typedef struct packed {
    logic [1:0]  cnt_pin_sync;   // Two-flop synchroniser, count pin.
    logic [1:0]  trg_pin_sync;   // Two-flop synchroniser, trigger pin.
    logic [1:0]  osc_pin_sync;   // Two-flop synchroniser, oscillator pin.
    logic        cnt_pin_prev;
    logic        trg_pin_prev;
    logic        osc_pin_prev;
    logic [15:0] first_count;
    logic        first_overflow_flag;
    logic        first_trigger_flag;
    logic [15:0] second_count;
    logic [7:0]  second_timer_control;
    logic [7:0]  second_timer_reload_low;
    logic [3:0]  sys_div;
    logic [2:0]  osc_div;
    logic [7:0]  rdata;
  } art_state_t;

endpackage

// >>> verilog/art_timers.sv
// Two 16-bit auto-reload timers of an 8-bit controller core.
// Assumes one synchronous clock domain; pins come in asynchronously and are synchronised here.
`timescale 1ns/1ps

module art_timers (
  input  wire logic                    clk_sys,                // System clock, 100 MHz.
  input  wire logic                    rst,                    // Synchronous reset, active high.
  input  wire logic [7:0]              sfr_addr,               // Register address.
  input  wire logic                    sfr_wr,                 // Write strobe.
  input  wire logic                    sfr_rd,                 // Read strobe.
  input  wire logic [7:0]              sfr_wdata,              // Write data.
  output      logic [7:0]              sfr_rdata,              // Read data, one cycle later.
  input  wire art_pkg::art_first_cfg_t first_cfg,              // First-timer settings.
  input  wire logic                    first_flag_clear,       // Clears first overflow flag.
  input  wire logic                    first_trig_clear,       // Clears trigger flag.
  input  wire logic [7:0]              second_reload_high,     // Second reload high byte.
  input  wire logic                    second_irq_enable,      // Second timer interrupt enable.
  input  wire logic                    external_count_pin,     // First timer count pin.
  input  wire logic                    external_trigger_pin,   // First timer trigger pin.
  input  wire logic                    external_osc_pin,       // External oscillator input.
  output      logic [15:0]             first_count,            // First timer count.
  output      logic                    first_overflow_flag,    // First timer overflow flag.
  output      logic                    first_trigger_flag,     // Trigger reload flag.
  output      logic                    first_irq,              // First timer interrupt request.
  output      logic [15:0]             second_count,           // Second timer count.
  output      logic                    second_irq              // Second timer interrupt request.
);
  import art_pkg::*;

  // Every flop of the block lives in s_q; s_d is its next value, built in one process.
  art_state_t s_q;
  art_state_t s_d;

  // ****************************************
  // Helpers
  // ****************************************

  // A falling edge on a synchronised pin, seen against its last sample.
  // The edge register resets low, so a pin that idles high gives no false edge after reset.
  function automatic logic fall(input logic prev, input logic cur);
    fall = prev & ~cur;
  endfunction

  // Count step with wrap detection; the wrap bit tells the caller to set the overflow flag and, in auto-reload mode, to reload.
  function automatic logic [16:0] step(input logic [15:0] cnt);
    step = {(cnt == ART_COUNT_MAX), 16'(cnt + 16'h0001)};
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************

  // Pins are only read through the second synchroniser flop, so no gate sees metastability.
  always_comb begin
    logic        cnt_fall;
    logic        trg_fall;
    logic        osc_fall;
    logic        first_tick;
    logic        first_wrap;
    logic        first_trig;
    logic [16:0] first_next;
    logic        sys_tick;
    logic        osc_tick;
    logic        second_tick;
    logic        second_wrap;
    logic [16:0] second_next;
    logic        ctl_wr;
    cnt_fall    = 1'b0;
    trg_fall    = 1'b0;
    osc_fall    = 1'b0;
    first_tick  = 1'b0;
    first_wrap  = 1'b0;
    first_trig  = 1'b0;
    first_next  = 17'h0_0000;
    sys_tick    = 1'b0;
    osc_tick    = 1'b0;
    second_tick = 1'b0;
    second_wrap = 1'b0;
    second_next = 17'h0_0000;
    ctl_wr      = 1'b0;
    s_d         = s_q;

    // Synchronisers shift each cycle; the edge registers keep the last synchronised level.
    s_d.cnt_pin_sync = {s_q.cnt_pin_sync[0], external_count_pin};
    s_d.trg_pin_sync = {s_q.trg_pin_sync[0], external_trigger_pin};
    s_d.osc_pin_sync = {s_q.osc_pin_sync[0], external_osc_pin};
    s_d.cnt_pin_prev = s_q.cnt_pin_sync[1];
    s_d.trg_pin_prev = s_q.trg_pin_sync[1];
    s_d.osc_pin_prev = s_q.osc_pin_sync[1];
    cnt_fall = fall(s_q.cnt_pin_prev, s_q.cnt_pin_sync[1]);
    trg_fall = fall(s_q.trg_pin_prev, s_q.trg_pin_sync[1]);
    osc_fall = fall(s_q.osc_pin_prev, s_q.osc_pin_sync[1]);

    // First timer: one increment per system cycle or per count pin falling edge.
    first_tick = first_cfg.run & (first_cfg.counter_source_select ? cnt_fall : 1'b1);
    first_next = step(s_q.first_count);
    first_wrap = first_tick & first_next[16];
    // The trigger only acts in auto-reload mode and with its enable set.
    first_trig = trg_fall & first_cfg.external_trigger_enable
                 & ~first_cfg.capture_reload_select;
    if (first_wrap && !first_cfg.capture_reload_select) begin
      s_d.first_count = first_cfg.reload;
    end else if (first_tick) begin
      s_d.first_count = first_next[15:0];
    end
    // A trigger reload outranks a plain increment in the same cycle.
    // Software reads the trigger flag, not the count, to learn that a trigger acted.
    if (first_trig) begin
      s_d.first_count = first_cfg.reload;
    end

    // Flags: a hardware set in the clearing cycle wins, so no event is lost.
    if (first_flag_clear) begin
      s_d.first_overflow_flag = 1'b0;
    end
    if (first_wrap) begin
      s_d.first_overflow_flag = 1'b1;
    end
    if (first_trig_clear) begin
      s_d.first_trigger_flag = 1'b0;
    end
    if (first_trig) begin
      s_d.first_trigger_flag = 1'b1;
    end

    // Second timer clock: divide by twelve always runs so the phase is steady.
    // Limitation: the first tick after a start may come early, as run does not reset it.
    sys_tick  = (s_q.sys_div == ART_SYS_DIV_LAST);
    s_d.sys_div = sys_tick ? 4'h0 : 4'(s_q.sys_div + 4'h1);
    if (osc_fall) begin
      s_d.osc_div = (s_q.osc_div == ART_XOSC_DIV_LAST) ? 3'h0 : 3'(s_q.osc_div + 3'h1);
    end
    // The oscillator must be well below half the system clock to be counted faithfully.
    osc_tick = osc_fall & (s_q.osc_div == ART_XOSC_DIV_LAST);
    if (s_q.second_timer_control[ART_CTL_XCLK_BIT]) begin
      second_tick = osc_tick;
    end else if (s_q.second_timer_control[ART_CTL_MODE_BIT]) begin
      second_tick = 1'b1;
    end else begin
      second_tick = sys_tick;
    end
    // Run gating comes last so one bit stops every clock source alike.
    second_tick = second_tick & s_q.second_timer_control[ART_CTL_RUN_BIT];
    second_next = step(s_q.second_count);
    second_wrap = second_tick & second_next[16];
    if (second_wrap) begin
      s_d.second_count = {second_reload_high, s_q.second_timer_reload_low};
    end else if (second_tick) begin
      s_d.second_count = second_next[15:0];
    end

    // Register writes; unused control bits are dropped and read as zero.
    ctl_wr = sfr_wr & (sfr_addr == ART_SECOND_TIMER_CONTROL_ADDR);
    if (ctl_wr) begin
      s_d.second_timer_control = sfr_wdata & ART_CTL_USED_MASK;
    end
    if (sfr_wr && sfr_addr == ART_SECOND_TIMER_RELOAD_LOW_ADDR) begin
      s_d.second_timer_reload_low = sfr_wdata;
    end
    // Overflow sets the sticky flag even against a software write of zero.
    if (second_wrap) begin
      s_d.second_timer_control[ART_CTL_FLAG_BIT] = 1'b1;
    end

    // Read data is registered; unmapped addresses read zero.
    // A read changes no register, so a repeated read is harmless.
    if (sfr_rd) begin
      case (sfr_addr)
        ART_SECOND_TIMER_CONTROL_ADDR:    s_d.rdata = s_q.second_timer_control;
        ART_SECOND_TIMER_RELOAD_LOW_ADDR: s_d.rdata = s_q.second_timer_reload_low;
        default:                          s_d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************

  // All state resets to constants, pins included.
  // Counts and registers are named again so their reset values stay visible.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.first_count             <= ART_COUNT_RESET;
      s_q.second_count            <= ART_COUNT_RESET;
      s_q.second_timer_control    <= ART_CTL_RESET;
      s_q.second_timer_reload_low <= ART_RELOAD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Counts and read data come straight from flops, so they never glitch.
  // Requests are levels that stand while a flag is set and its enable is on.
  assign sfr_rdata           = s_q.rdata;
  assign first_count         = s_q.first_count;
  assign first_overflow_flag = s_q.first_overflow_flag;
  assign first_trigger_flag  = s_q.first_trigger_flag;
  assign first_irq           = first_cfg.irq_enable
                               & (s_q.first_overflow_flag | s_q.first_trigger_flag);
  assign second_count        = s_q.second_count;
  assign second_irq          = second_irq_enable
                               & s_q.second_timer_control[ART_CTL_FLAG_BIT];

endmodule

// >>> verification/art_timers_properties.sv
// Port-level checker for the auto-reload timers.
// Assumes it is bound to art_timers and sees only that module's ports.
`timescale 1ns/1ps
module art_timers_chk (
  input wire logic                    clk_sys,             // System clock.
  input wire logic                    rst,                 // Synchronous reset.
  input wire logic                    sfr_rd,              // Read strobe.
  input wire logic [7:0]              sfr_rdata,           // Read data.
  input wire art_pkg::art_first_cfg_t first_cfg,           // First-timer settings.
  input wire logic                    first_flag_clear,    // Overflow flag clear.
  input wire logic                    second_irq_enable,   // Second interrupt enable.
  input wire logic [15:0]             first_count,         // First count.
  input wire logic                    first_overflow_flag, // First overflow flag.
  input wire logic                    first_trigger_flag,  // Trigger flag.
  input wire logic                    first_irq,           // First request.
  input wire logic                    second_irq           // Second request.
);
  import art_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Trigger enable is excluded because a pending pin edge may override an increment.
  logic inc_free;
  assign inc_free = first_cfg.run & ~first_cfg.counter_source_select
                    & ~first_cfg.external_trigger_enable;
  sequence s_top;
    inc_free && first_count == ART_COUNT_MAX;
  endsequence
  sequence s_wrapped;
    first_overflow_flag && first_count == $past(first_cfg.reload);
  endsequence
  AST_RELOAD: assert property (s_top and !first_cfg.capture_reload_select |=> s_wrapped)
    else $error("reload after wrap missing");
  AST_CAPWRAP: assert property (s_top and first_cfg.capture_reload_select |=>
    first_count == ART_COUNT_RESET && first_overflow_flag) else $error("capture wrap wrong");
  AST_INC: assert property (inc_free && first_count != ART_COUNT_MAX |=>
    first_count == $past(first_count) + 16'h0001) else $error("increment wrong");
  AST_HOLD: assert property (!first_cfg.run && !first_cfg.external_trigger_enable |=>
    $stable(first_count)) else $error("stopped count moved");
  AST_STICKY: assert property (first_overflow_flag && !first_flag_clear |=>
    first_overflow_flag) else $error("overflow flag dropped");
  AST_IRQ1: assert property (first_irq == (first_cfg.irq_enable &&
    (first_overflow_flag || first_trigger_flag))) else $error("first request wrong");
  AST_IRQ2: assert property (!second_irq_enable |-> !second_irq)
    else $error("masked second request");
  AST_RDATA: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved");
endmodule
bind art_timers art_timers_chk i_art_timers_chk (.clk_sys(clk_sys), .rst(rst),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .first_cfg(first_cfg),
  .first_flag_clear(first_flag_clear), .second_irq_enable(second_irq_enable),
  .first_count(first_count), .first_overflow_flag(first_overflow_flag),
  .first_trigger_flag(first_trigger_flag), .first_irq(first_irq), .second_irq(second_irq));

// >>> verification/test_autoreload_timers.sv
// Self-checking bench for the auto-reload timers.
// Assumes the art_pkg package and art_timers; inputs change at falling edges.
`timescale 1ns/1ps
module test_autoreload_timers;
  import art_pkg::*;
  typedef struct {int k; logic [15:0] v;} art_note_t;
  art_note_t      notes[$];
  art_note_t      nt;
  art_first_cfg_t cfg = '0;
  logic clk_sys = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, s_ien = 1, fclr = 0, tclr = 0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [2:0]  pins = 3'b111;
  logic [15:0] first_count, second_count, rl;
  logic        f_ovf, f_trg, f_irq, s_irq;
  int          seed = 32'h7a58_d575, n, err_total = 0, checked = 0, cyc = 0;
  art_timers i_art_timers (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .first_cfg(cfg), .first_flag_clear(fclr), .first_trig_clear(tclr),
    .second_reload_high(8'hFF), .second_irq_enable(s_ien), .external_count_pin(pins[0]),
    .external_trigger_pin(pins[1]), .external_osc_pin(pins[2]), .first_count(first_count),
    .first_overflow_flag(f_ovf), .first_trigger_flag(f_trg), .first_irq(f_irq),
    .second_count(second_count), .second_irq(s_irq));
  // ****************************************
  // Drivers, notes and comparisons
  // ****************************************
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Each kind of result has its own compare task; all of them count into one tally.
  task tally(string nm, logic [15:0] e, logic [15:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task chk_rdata(logic [15:0] e);
    tally("sfr_rdata", e, {8'h00, sfr_rdata});
  endtask
  task chk_first(logic [15:0] e);
    tally("first_count", e, first_count);
  endtask
  task chk_second(logic [15:0] e);
    tally("second_count", e, second_count);
  endtask
  task chk_flags(logic [15:0] e);
    tally("flags", e, {12'h000, f_ovf, f_trg, f_irq, s_irq});
  endtask
  // A note is pushed at a falling edge, and a falling edge passes before the next one.
  task ex(int k, logic [15:0] v);
    notes.push_back('{k, v});
    @(negedge clk_sys);
  endtask
  // The watcher runs at the rising edge before any flop updates, so it sees values that
  // have stood since the previous edge; one note at the most is pending.
  always @(posedge clk_sys) begin
    if (notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt.k)
        0: chk_rdata(nt.v);
        1: chk_first(nt.v);
        2: chk_second(nt.v);
        default: chk_flags(nt.v);
      endcase
    end
  end
  // A strobe drops after one cycle and stays low over a rising edge before the next call.
  task wr(logic [7:0] a, logic [7:0] d);
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(negedge clk_sys) sfr_wr = 0;
    @(negedge clk_sys);
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    {sfr_rd, sfr_addr} = {1'b1, a};
    @(negedge clk_sys) sfr_rd = 0;
    ex(0, {8'h00, e});
  endtask
  // Each level is held long enough to pass the two-flop synchroniser.
  task pulse(int i, int k);
    repeat (k) begin
      pins[i] = 0;
      repeat (4) @(negedge clk_sys);
      pins[i] = 1;
      repeat (4) @(negedge clk_sys);
    end
  endtask
  task summarize;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 0;
    rd(8'h91, 8'h00);
    n = $random(seed);
    wr(8'h92, n[7:0]);
    wr(8'h93, 8'hFF);
    rd(8'h92, n[7:0]);
    rd(8'h93, 8'h00);
    wr(8'h91, 8'h78);
    rd(8'h91, 8'h00);
    {cfg.reload, cfg.external_trigger_enable, cfg.irq_enable} = {16'hFFFD, 2'b11};
    pulse(1, 1);
    ex(1, 16'hFFFD);
    ex(3, 16'h0006);
    tclr = 1;
    @(negedge clk_sys) tclr = 0;
    n = $random(seed);
    rl = {1'b0, n[14:0]};
    {cfg.reload, cfg.external_trigger_enable} = {rl, 1'b0};
    pulse(1, 1);
    ex(1, 16'hFFFD);
    cfg.run = 1;
    repeat (3) @(negedge clk_sys);
    cfg.run = 0;
    ex(1, rl);
    ex(3, 16'h000A);
    n = ($random(seed) & 15) + 1;
    cfg.run = 1;
    repeat (n) @(negedge clk_sys);
    {cfg.run, fclr} = 2'b01;
    @(negedge clk_sys) fclr = 0;
    ex(1, rl + 16'(n));
    ex(3, 16'h0000);
    {cfg.counter_source_select, cfg.run} = 2'b11;
    pulse(0, 3);
    cfg.run = 0;
    ex(1, rl + 16'(n + 3));
    {cfg.capture_reload_select, cfg.external_trigger_enable} = 2'b11;
    pulse(1, 1);
    ex(1, rl + 16'(n + 3));
    // With capture-or-reload select at one the count wraps to zero and ignores the reload.
    {cfg.capture_reload_select, cfg.counter_source_select, cfg.reload} = {2'b00, 16'hFFFE};
    pulse(1, 1);
    {cfg.capture_reload_select, cfg.external_trigger_enable, cfg.run} = 3'b101;
    repeat (3) @(negedge clk_sys);
    cfg.run = 0;
    ex(1, 16'h0001);
    ex(3, 16'h000E);
    {fclr, tclr} = 2'b11;
    @(negedge clk_sys) {fclr, tclr} = 2'b00;
    wr(8'h92, 8'hFE);
    wr(8'h91, 8'h06);
    // The wrap falls on the edge that takes the write of zero to the flag, and the set wins.
    repeat (65534) @(negedge clk_sys);
    wr(8'h91, 8'h02);
    rd(8'h91, 8'h82);
    ex(2, 16'hFFFE);
    ex(3, 16'h0001);
    s_ien = 0;
    ex(3, 16'h0000);
    s_ien = 1;
    wr(8'h91, 8'h00);
    ex(3, 16'h0000);
    wr(8'h92, 8'h00);
    wr(8'h91, 8'h04);
    // Twenty-four running edges hold exactly two ticks of the divide by twelve, in any phase.
    repeat (22) @(negedge clk_sys);
    wr(8'h91, 8'h00);
    ex(2, 16'hFF00);
    wr(8'h91, 8'h05);
    pulse(2, 8);
    wr(8'h91, 8'h00);
    ex(2, 16'hFF01);
    summarize();
  end
endmodule
